// file: mst_bus_if.sv
`default_nettype none
// =====================================================
// register access between serial engine and bank
interface mst_bus_if;
  logic [12:0] addr;   // register offset
  logic [7:0]  wdata;  // write byte
  logic        wr;     // one-cycle write strobe
  logic [7:0]  rdata;  // read byte for addr
  modport eng  (output addr, output wdata, output wr, input rdata);
  modport bank (input addr, input wdata, input wr, output rdata);
endinterface
`default_nettype wire

// file: mst_host_model.sv
`default_nettype none
// =====================================================
// host controller on the serial control port
module mst_host_model (
  // clock used for pacing
  input  wire logic clk,
  // port pins
  output logic      sclk,
  output logic      cs_n,
  output logic      sdo,
  output logic      sdo_en,
  input  wire logic sdi
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle frame lines at time zero
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdo = 1'b0;
    sdo_en = 1'b1;
  end

  // six system cycles a half period, above the three-cycle minimum
  task automatic half();
    repeat (6) @(negedge clk);
  endtask

  // =====================================================
  // one frame: 16 command bits then one byte, msb first
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
                      output logic [7:0] rdat);
    logic [23:0] f;
    f = {rd, 2'b00, a, wd};
    rdat = 8'h00;
    cs_n = 1'b0;
    half();
    for (int i = 23; i >= 0; i--) begin
      // read byte phase: host lets go of the data line
      if (rd && i < 8) begin
        sdo_en = 1'b0;
      end else begin
        sdo = f[i];
      end
      half();
      // sample just before the rise, long after the device shifted
      if (rd && i < 8) begin
        rdat[i] = sdi;
      end
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    sdo_en = 1'b1;
    half();
  endtask
endmodule // mst_host_model
`default_nettype wire

// file: mst_map.svh
`ifndef MST_MAP_SVH
`define MST_MAP_SVH
// =====================================================
// register offsets on the serial control port
`define MST_A_ALIGN  13'h100
`define MST_A_FD     13'h104
`define MST_A_COARSE 13'h105
`define MST_A_FHI_L  13'h106
`define MST_A_FHI_H  13'h107
`define MST_A_FLO_L  13'h108
`define MST_A_FLO_H  13'h109
`define MST_A_DCA_L  13'h10D
`define MST_A_DCA_H  13'h10E
`define MST_A_DCB_L  13'h10F
`define MST_A_DCB_H  13'h110
`define MST_A_MSP    13'h111
`define MST_A_CFG    13'h112
`define MST_A_PER0   13'h113
`define MST_A_PER1   13'h114
`define MST_A_PER2   13'h115
`define MST_A_RESA0  13'h116
`define MST_A_RESA1  13'h117
`define MST_A_RESA2  13'h118
`define MST_A_RESB0  13'h119
`define MST_A_RESB1  13'h11A
`define MST_A_RESB2  13'h11B
// =====================================================
// field positions, reset values, counts
`define MST_B_MASTER 0
`define MST_B_DIV    1
`define MST_B_ONCE   2
`define MST_B_MON    7
`define MST_RST_MSP  7'h04
`define MST_PER_RST  24'h000080
`define MST_PER_MIN  24'h000080
`define MST_CMD_LAST 4'hF
`define MST_DAT_LAST 4'h7
`endif

// file: mst_pkg.sv
`default_nettype none
// =====================================================
// shared types
package mst_pkg;
  // result source chosen by the monitor mode field
  typedef enum logic [1:0] {SRC_POWER, SRC_PEAK, SRC_THRESH} mst_src_t;
  // serial port transfer phase
  typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_DATA, PH_DONE} mst_ph_t;

  // serial port engine state
  typedef struct packed {
    logic        sclk_m1, sclk_m2, sclk_d;
    logic        cs_m1, cs_m2;
    logic        din_m1, din_m2;
    mst_ph_t     phase;
    logic [3:0]  bitcnt;
    logic [15:0] sh_in;
    logic        rw;
    logic [12:0] addr;
    logic        rd, rd_q, wr;
    logic [7:0]  wdata;
    logic [7:0]  sh_out;
    logic        dout, oe;
  } mst_spi_st_t;

  // register bank state
  typedef struct packed {
    logic        sync_m1, sync_m2, sync_d;
    logic        al_master, al_div, al_once, al_mon;
    logic        fd_en;
    logic [2:0]  fd_mode;
    logic [2:0]  coarse;
    logic [12:0] fhi, flo;
    logic [6:0]  msp;
    logic        cpx, ms;
    logic [1:0]  mode;
    logic        mon_en;
    logic [23:0] period, per_eff;
    logic [2:0]  divcnt;
    logic        tick, to_mon, to_div, phase;
    logic        crs_a, fhi_a, flo_a, crs_b, fhi_b, flo_b;
    logic [3:0]  fd_out, fd_oe;
    mst_src_t    src;
  } mst_top_st_t;
endpackage
`default_nettype wire

// file: mst_regs.sv
// Contract
// R1 - no alignment pulse without master enable
// R2 - monitor gets pulses when its enable set
// R3 - divider gets pulses when its enable set
// R4 - single mode: divider takes only first pulse
// R5 - single mode clears divider enable itself
// R6 - overrange pins driven only when enabled
// R7 - interleaved: tristate only when both off
// R8 - 3-bit code sets coarse upper level
// R9 - fine high flag when magnitude above limit
// R10 - fine low flag when magnitude below limit
// R11 - fine limits split low byte, high 5 bits
// R12 - dc offsets read-only, 14 bits, two bytes
// R13 - 20-bit results read-only over three bytes
// R14 - shift clock divides by 2, 4, 8
// R15 - enables pick fields shifted out serially
// R16 - mode field selects result source, rms/ms
// R17 - measurement period floor is 128 cycles
// R18 - open bits read zero, read-only ignore writes
`default_nettype none
`include "mst_map.svh"
module mst_regs (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  // serial control port pins
  input  wire logic        SPI_SCLK,
  input  wire logic        SPI_CS_N,
  input  wire logic        SPI_SDIO_IN,
  output logic             SPI_SDIO_OUT,
  output logic             SPI_SDIO_OE,
  // external alignment pulse and its gated copies
  input  wire logic        SYNC_IN,
  output logic             SYNC_TO_MONITOR,
  output logic             SYNC_TO_DIVIDER,
  // sample magnitudes and channel state
  input  wire logic [12:0] MAG_A,
  input  wire logic [12:0] MAG_B,
  input  wire logic        CHAN_A_OFF,
  input  wire logic        CHAN_B_OFF,
  input  wire logic        INTERLEAVED,
  // fast overrange pins
  output logic [3:0]       FD_OUT,
  output logic [3:0]       FD_OE,
  // monitor results
  input  wire logic [13:0] DC_OFS_A,
  input  wire logic [13:0] DC_OFS_B,
  input  wire logic [19:0] MEAS_A,
  input  wire logic [19:0] MEAS_B,
  input  wire logic        MON_DATA_PENDING,
  // monitor settings
  output logic             MON_ENABLE,
  output logic             MON_COMPLEX,
  output logic             MON_MS_SELECT,
  output logic [1:0]       MON_SOURCE,
  output logic [23:0]      MON_PERIOD,
  // monitor serial port settings
  output logic             MON_PORT_ENABLE,
  output logic             MON_PORT_POWER_EN,
  output logic             MON_PORT_PEAK_EN,
  output logic             MON_PORT_THRESH_EN,
  output logic             MON_SHIFT_TICK
);
  mst_pkg::mst_top_st_t s, n;   // whole bank state and its next value
  mst_bus_if            bus ();  // link to the serial engine
  logic                 sync_edge;
  logic [1:0]           fd_a, fd_b, fd_pair;
  logic [2:0]           div_last;
  logic                 tick_gate;
  logic [7:0]           rdata;
  // assertions below run on the system clock, off during reset
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  // =====================================================
  // serial control port engine
  mst_spi_slave u_spi (
    .clk      (CLK_SYS),
    .rst      (RESET),
    .sclk     (SPI_SCLK),
    .cs_n     (SPI_CS_N),
    .sdio_in  (SPI_SDIO_IN),
    .sdio_out (SPI_SDIO_OUT),
    .sdio_oe  (SPI_SDIO_OE),
    .bus      (bus.eng)
  );

  // =====================================================
  // helper terms
  // rising edge after the synchroniser, pin never read raw
  assign sync_edge = s.sync_m2 & ~s.sync_d;

  // per-channel pin pair: mode 0 shows coarse, others fine high
  assign fd_a = {s.flo_a, (s.fd_mode == 3'h0) ? s.crs_a : s.fhi_a};
  assign fd_b = {s.flo_b, (s.fd_mode == 3'h0) ? s.crs_b : s.fhi_b};

  // interleaved pair: alternate channels, repeat the live one
  assign fd_pair = (CHAN_B_OFF || (!CHAN_A_OFF && !s.phase)) ? fd_a : fd_b; // R7

  // shift clock divide: 01 -> 2, 10 -> 4, 11 -> 8
  always_comb begin
    unique case (s.msp[3:2])
      2'b10:   div_last = 3'h3; // R14
      2'b11:   div_last = 3'h7; // R14
      // code 00 is undefined; run it as divide by 2
      default: div_last = 3'h1; // R14
    endcase
  end

  // sleep holds the shift clock low while nothing waits
  assign tick_gate = ~(s.msp[1] & ~MON_DATA_PENDING);

  // =====================================================
  // register read mux, open bits read zero
  always_comb begin
    rdata = 8'h00; // R18
    unique case (bus.addr)
      `MST_A_ALIGN:  rdata = {s.al_mon, 4'h0, s.al_once, s.al_div, s.al_master};
      `MST_A_FD:     rdata = {4'h0, s.fd_mode, s.fd_en};
      `MST_A_COARSE: rdata = {5'h00, s.coarse};
      `MST_A_FHI_L:  rdata = s.fhi[7:0];
      `MST_A_FHI_H:  rdata = {3'h0, s.fhi[12:8]};
      `MST_A_FLO_L:  rdata = s.flo[7:0];
      `MST_A_FLO_H:  rdata = {3'h0, s.flo[12:8]};
      `MST_A_DCA_L:  rdata = DC_OFS_A[7:0]; // R12
      `MST_A_DCA_H:  rdata = {2'h0, DC_OFS_A[13:8]}; // R12
      `MST_A_DCB_L:  rdata = DC_OFS_B[7:0]; // R12
      `MST_A_DCB_H:  rdata = {2'h0, DC_OFS_B[13:8]}; // R12
      `MST_A_MSP:    rdata = {1'b0, s.msp};
      `MST_A_CFG:    rdata = {s.cpx, 3'h0, s.ms, s.mode, s.mon_en};
      `MST_A_PER0:   rdata = s.period[7:0];
      `MST_A_PER1:   rdata = s.period[15:8];
      `MST_A_PER2:   rdata = s.period[23:16];
      `MST_A_RESA0:  rdata = MEAS_A[7:0]; // R13
      `MST_A_RESA1:  rdata = MEAS_A[15:8]; // R13
      `MST_A_RESA2:  rdata = {4'h0, MEAS_A[19:16]}; // R13
      `MST_A_RESB0:  rdata = MEAS_B[7:0]; // R13
      `MST_A_RESB1:  rdata = MEAS_B[15:8]; // R13
      `MST_A_RESB2:  rdata = {4'h0, MEAS_B[19:16]}; // R13
      // unmapped offsets read as zero
      default:       rdata = 8'h00; // R18
    endcase
  end
  assign bus.rdata = rdata;

  // =====================================================
  // next state
  always_comb begin
    n = s;
    // alignment pin synchroniser and edge history
    n.sync_m1 = SYNC_IN;
    n.sync_m2 = s.sync_m1;
    n.sync_d  = s.sync_m2;

    // gating of the alignment pulse
    n.to_mon = sync_edge & s.al_master & s.al_mon; // R1 R2
    n.to_div = sync_edge & s.al_master & s.al_div; // R1 R3
    // single mode: first pass drops the divider enable
    if (n.to_div && s.al_once) begin
      n.al_div = 1'b0; // R4 R5
    end

    // threshold flags, one cycle behind the magnitude
    n.crs_a = MAG_A >= {s.coarse, 10'h000}; // R8
    n.crs_b = MAG_B >= {s.coarse, 10'h000}; // R8
    n.fhi_a = MAG_A > s.fhi; // R9
    n.fhi_b = MAG_B > s.fhi; // R9
    n.flo_a = MAG_A < s.flo; // R10
    n.flo_b = MAG_B < s.flo; // R10

    // overrange pins
    n.phase = ~s.phase;
    if (!s.fd_en) begin
      // disabled: released to high impedance
      n.fd_oe  = 4'h0; // R6
      n.fd_out = 4'h0;
    end else if (INTERLEAVED) begin
      // shared pins stay driven while any channel lives
      n.fd_oe  = {4{~(CHAN_A_OFF & CHAN_B_OFF)}}; // R7
      n.fd_out = {fd_pair, fd_pair}; // R7
    end else begin
      n.fd_oe  = 4'hF; // R6
      n.fd_out = {fd_b, fd_a}; // R6
    end

    // monitor shift clock enable from the divider
    n.tick = 1'b0;
    if (!tick_gate) begin
      n.divcnt = 3'h0;
    end else if (s.divcnt >= div_last) begin
      n.divcnt = 3'h0;
      n.tick   = 1'b1; // R14
    end else begin
      n.divcnt = s.divcnt + 3'h1;
    end

    // result source decode; 10 and 11 both mean threshold
    unique case (s.mode)
      2'b00:   n.src = mst_pkg::SRC_POWER; // R16
      2'b01:   n.src = mst_pkg::SRC_PEAK; // R16
      default: n.src = mst_pkg::SRC_THRESH; // R16
    endcase

    // short windows are stretched to the floor
    n.per_eff = (s.period < `MST_PER_MIN) ? `MST_PER_MIN : s.period; // R17

    // register writes; software beats the self-clear
    if (bus.wr) begin
      unique case (bus.addr)
        `MST_A_ALIGN: begin
          n.al_master = bus.wdata[`MST_B_MASTER];
          n.al_div    = bus.wdata[`MST_B_DIV];
          n.al_once   = bus.wdata[`MST_B_ONCE];
          n.al_mon    = bus.wdata[`MST_B_MON];
        end
        `MST_A_FD: begin
          n.fd_en   = bus.wdata[0];
          n.fd_mode = bus.wdata[3:1];
        end
        `MST_A_COARSE: n.coarse = bus.wdata[2:0]; // R8
        `MST_A_FHI_L:  n.fhi[7:0] = bus.wdata; // R11
        `MST_A_FHI_H:  n.fhi[12:8] = bus.wdata[4:0]; // R11
        `MST_A_FLO_L:  n.flo[7:0] = bus.wdata; // R11
        `MST_A_FLO_H:  n.flo[12:8] = bus.wdata[4:0]; // R11
        `MST_A_MSP:    n.msp = bus.wdata[6:0]; // R15
        `MST_A_CFG: begin
          n.cpx    = bus.wdata[7];
          n.ms     = bus.wdata[3]; // R16
          n.mode   = bus.wdata[2:1]; // R16
          n.mon_en = bus.wdata[0];
        end
        `MST_A_PER0: n.period[7:0] = bus.wdata;
        `MST_A_PER1: n.period[15:8] = bus.wdata;
        `MST_A_PER2: n.period[23:16] = bus.wdata;
        // read-only and unmapped offsets drop the write
        default: ; // R18
      endcase
    end
  end

  // =====================================================
  // state register
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      s          <= '0;
      s.msp      <= `MST_RST_MSP;
      s.period   <= `MST_PER_RST;
      s.per_eff  <= `MST_PER_MIN;
    end else begin
      s <= n;
    end
  end

  // =====================================================
  // outputs, all straight from the state register
  assign SYNC_TO_MONITOR    = s.to_mon;
  assign SYNC_TO_DIVIDER    = s.to_div;
  assign FD_OUT             = s.fd_out;
  assign FD_OE              = s.fd_oe;
  assign MON_ENABLE         = s.mon_en;
  assign MON_COMPLEX        = s.cpx;
  assign MON_MS_SELECT      = s.ms;
  assign MON_SOURCE         = s.src;
  assign MON_PERIOD         = s.per_eff;
  assign MON_PORT_ENABLE    = s.msp[0];
  assign MON_PORT_THRESH_EN = s.msp[4]; // R15
  assign MON_PORT_PEAK_EN   = s.msp[5]; // R15
  assign MON_PORT_POWER_EN  = s.msp[6]; // R15
  assign MON_SHIFT_TICK     = s.tick;

  // =====================================================
  // checks

  // a single-mode divider pass with no write in the way
  sequence s_once_fire;
    sync_edge && s.al_master && s.al_div && s.al_once && !bus.wr;
  endsequence

  // quiet bus for three cycles after it
  sequence s_once_quiet;
    s_once_fire ##1 (!bus.wr) [*3];
  endsequence

  AST_MASTER_GATE: assert property ( // R1
    (SYNC_TO_MONITOR || SYNC_TO_DIVIDER) |-> $past(s.al_master))
    else $error("alignment pulse passed with master enable low");

  AST_MON_PASS: assert property ( // R2
    (sync_edge && s.al_master && s.al_mon) |=> SYNC_TO_MONITOR)
    else $error("monitor alignment pulse lost");

  AST_DIV_PASS: assert property ( // R3
    (sync_edge && s.al_master && s.al_div) |=> SYNC_TO_DIVIDER)
    else $error("divider alignment pulse lost");

  AST_ONCE_CLEAR: assert property ( // R5
    s_once_fire |=> !s.al_div)
    else $error("divider enable not cleared after single alignment");

  AST_ONCE_ONLY: assert property ( // R4
    s_once_quiet |=> !SYNC_TO_DIVIDER)
    else $error("divider aligned again in single mode");

  AST_FD_RELEASE: assert property ( // R6
    !s.fd_en |=> (FD_OE == 4'h0))
    else $error("overrange pins driven while disabled");

  AST_FD_BOTH_OFF: assert property ( // R7
    (s.fd_en && INTERLEAVED && CHAN_A_OFF && CHAN_B_OFF) |=> (FD_OE == 4'h0))
    else $error("interleaved pins driven with both channels off");

  AST_FD_REPEAT: assert property ( // R7
    (s.fd_en && INTERLEAVED && CHAN_A_OFF && !CHAN_B_OFF)
    |=> (FD_OE == 4'hF) && (FD_OUT[1:0] == $past(fd_b)))
    else $error("interleaved pins not repeating the live channel");

  AST_COARSE_LVL: assert property ( // R8
    (MAG_A >= {s.coarse, 10'h000}) |=> s.crs_a)
    else $error("coarse flag missing at programmed level");

  AST_FINE_HIGH: assert property ( // R9
    (MAG_B > s.fhi) |=> s.fhi_b)
    else $error("fine high flag missing above limit");

  AST_FINE_LOW: assert property ( // R10
    (MAG_A < s.flo) |=> s.flo_a)
    else $error("fine low flag missing below limit");

  AST_DIV_BY_TWO: assert property ( // R14
    (MON_SHIFT_TICK && s.msp[3:2] == 2'b01 && !s.msp[1] && !bus.wr)
    |=> !MON_SHIFT_TICK ##1 MON_SHIFT_TICK)
    else $error("shift clock enable not every second cycle");

  AST_SRC_THRESH: assert property ( // R16
    (s.mode[1] && !bus.wr) |=> (MON_SOURCE == mst_pkg::SRC_THRESH) [*2])
    else $error("threshold source not selected");

  AST_PERIOD_FLOOR: assert property ( // R17
    MON_PERIOD >= `MST_PER_MIN)
    else $error("measurement period below floor");

  // a short programmed window must show up as exactly the floor
  AST_PERIOD_STRETCH: assert property ( // R17
    (s.period < `MST_PER_MIN) |=> (MON_PERIOD == `MST_PER_MIN))
    else $error("short measurement period not stretched");

  AST_OPEN_ZERO: assert property ( // R18
    (bus.addr == `MST_A_RESB2 || bus.addr == `MST_A_DCA_H) |-> (bus.rdata[7:6] == 2'h0))
    else $error("open bits read nonzero");
endmodule // mst_regs
`default_nettype wire

// file: mst_spi_slave.sv
`default_nettype none
`include "mst_map.svh"
// =====================================================
// serial control port engine: 16-bit command, one byte
module mst_spi_slave (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // port pins, asynchronous to clk
  input  wire logic   sclk,
  input  wire logic   cs_n,
  input  wire logic   sdio_in,
  output logic        sdio_out,
  output logic        sdio_oe,
  // register side
  mst_bus_if.eng      bus
);
  mst_pkg::mst_spi_st_t s, n;
  logic rise, fall;

  // edges seen past the second synchroniser stage only
  assign rise = s.sclk_m2 & ~s.sclk_d;
  assign fall = ~s.sclk_m2 & s.sclk_d;

  // =====================================================
  // next state
  always_comb begin
    n = s;
    n.sclk_m1 = sclk;
    n.sclk_m2 = s.sclk_m1;
    n.sclk_d  = s.sclk_m2;
    n.cs_m1   = cs_n;
    n.cs_m2   = s.cs_m1;
    n.din_m1  = sdio_in;
    n.din_m2  = s.din_m1;
    n.wr      = 1'b0;
    n.rd      = 1'b0;
    n.rd_q    = s.rd;
    // read byte captured one cycle after the fetch
    if (s.rd_q) begin
      n.sh_out = bus.rdata;
    end
    if (s.cs_m2) begin
      // deselect aborts any transfer and frees the pin
      n.phase = mst_pkg::PH_IDLE;
      n.oe    = 1'b0;
    end else begin
      unique case (s.phase)
        mst_pkg::PH_IDLE: begin
          n.phase  = mst_pkg::PH_CMD;
          n.bitcnt = 4'h0;
        end
        mst_pkg::PH_CMD: if (rise) begin
          n.sh_in  = {s.sh_in[14:0], s.din_m2};
          n.bitcnt = s.bitcnt + 4'h1;
          if (s.bitcnt == `MST_CMD_LAST) begin
            n.phase = mst_pkg::PH_DATA;
            n.rw    = n.sh_in[15];
            n.addr  = n.sh_in[12:0];
            n.rd    = n.sh_in[15];
          end
        end
        mst_pkg::PH_DATA: begin
          if (rise) begin
            n.wdata  = {s.wdata[6:0], s.din_m2};
            n.bitcnt = s.bitcnt + 4'h1;
            if (s.bitcnt == `MST_DAT_LAST) begin
              n.phase = mst_pkg::PH_DONE;
              n.wr    = ~s.rw;
            end
          end
          // read data changes on falling edges, msb first
          if (fall && s.rw) begin
            n.dout   = s.sh_out[7];
            n.sh_out = {s.sh_out[6:0], 1'b0};
            n.oe     = 1'b1;
          end
        end
        // further clocks ignored until deselect
        mst_pkg::PH_DONE: n.phase = mst_pkg::PH_DONE;
      endcase
    end
  end

  // =====================================================
  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s        <= '0;
      s.cs_m1  <= 1'b1;
      s.cs_m2  <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign bus.addr  = s.addr;
  assign bus.wdata = s.wdata;
  assign bus.wr    = s.wr;
  assign sdio_out  = s.dout;
  assign sdio_oe   = s.oe;
endmodule // mst_spi_slave
`default_nettype wire

// file: test_monitor_sync_threshold_regs.sv
`default_nettype none
`include "mst_map.svh"
// =====================================================
// bench: serial register access plus pin level checks
module test_monitor_sync_threshold_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, reset, sclk, cs_n, hdat, hen, sdio, dout, doe;   // clock, reset, serial port
  logic        sync_in, to_mon, to_div, a_off, b_off, ilv, pend;         // alignment and channel state
  logic [12:0] mag_a, mag_b;                                             // sample magnitudes
  logic [3:0]  fd_out, fd_oe;                                            // overrange pins
  logic [13:0] dc_a, dc_b;                                               // offset results
  logic [19:0] ms_a, ms_b;                                               // measurement results
  logic        m_en, m_cpx, m_ms, p_en, p_pw, p_pk, p_th, tick;          // monitor settings
  logic [1:0]  m_src;                                                    // result source
  logic [23:0] m_per;                                                    // effective period
  int          fail_count;                                               // mismatches
  int          check_count;                                              // comparisons
  logic [7:0]  r;                                                        // last read byte
  logic [12:0] ma [7] = '{13'h100, 13'h104, 13'h105, 13'h107, 13'h109, 13'h111, 13'h112};
  logic [7:0]  mk [7] = '{8'h87, 8'h0F, 8'h07, 8'h1F, 8'h1F, 8'h7F, 8'h8F};
  logic [7:0]  ro [10] = '{8'hBC, 8'h3A, 8'h34, 8'h12, 8'hDE, 8'hBC, 8'h0A, 8'h0D, 8'hF0, 8'h05};
  logic [7:0]  cf [6] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h08, 8'h80};
  logic [4:0]  ce [6] = '{5'h01, 5'h03, 5'h05, 5'h05, 5'h08, 5'h10};

  // shared data wire: a released line shows the inverse, not a stale value
  assign sdio = doe ? dout : (hen ? hdat : ~hdat);

  mst_regs u_dut (
    .CLK_SYS(clk_sys), .RESET(reset), .SPI_SCLK(sclk), .SPI_CS_N(cs_n), .SPI_SDIO_IN(sdio),
    .SPI_SDIO_OUT(dout), .SPI_SDIO_OE(doe), .SYNC_IN(sync_in), .SYNC_TO_MONITOR(to_mon),
    .SYNC_TO_DIVIDER(to_div), .MAG_A(mag_a), .MAG_B(mag_b), .CHAN_A_OFF(a_off), .CHAN_B_OFF(b_off),
    .INTERLEAVED(ilv), .FD_OUT(fd_out), .FD_OE(fd_oe), .DC_OFS_A(dc_a), .DC_OFS_B(dc_b),
    .MEAS_A(ms_a), .MEAS_B(ms_b), .MON_DATA_PENDING(pend), .MON_ENABLE(m_en), .MON_COMPLEX(m_cpx),
    .MON_MS_SELECT(m_ms), .MON_SOURCE(m_src), .MON_PERIOD(m_per), .MON_PORT_ENABLE(p_en),
    .MON_PORT_POWER_EN(p_pw), .MON_PORT_PEAK_EN(p_pk), .MON_PORT_THRESH_EN(p_th), .MON_SHIFT_TICK(tick));

  mst_host_model u_host (.clk(clk_sys), .sclk(sclk), .cs_n(cs_n), .sdo(hdat), .sdo_en(hen), .sdi(sdio));

  // =====================================================
  // shared tasks
  task automatic end_sim();
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // write lands four cycles after the last rise; eight gives margin
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, r);
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    u_host.xfer(1'b1, a, 8'h00, r);
    chk(r, e);
  endtask
  // one pin pulse, then count gated pulses over the next eight cycles
  task automatic pulse(input int em, input int ed);
    int m;
    int d;
    m = 0;
    d = 0;
    sync_in = 1'b1;
    repeat (2) @(negedge clk_sys);
    sync_in = 1'b0;
    repeat (8) begin
      @(negedge clk_sys);
      m += (to_mon === 1'b1);
      d += (to_div === 1'b1);
    end
    chk(m, em);
    chk(d, ed);
  endtask
  // flags plus pins take two cycles; four leaves margin
  task automatic fd(input logic [12:0] m, input logic [1:0] e);
    mag_a = m;
    repeat (4) @(negedge clk_sys);
    chk(fd_out[1:0], e);
  endtask
  task automatic ticks(input int e);
    int c;
    c = 0;
    repeat (16) begin
      @(negedge clk_sys);
      c += (tick === 1'b1);
    end
    chk(c, e);
  endtask

  // =====================================================
  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    fail_count++;
    end_sim();
  end

  // =====================================================
  // main sequence
  initial begin
    fail_count = 0;
    check_count = 0;
    {reset, sync_in, a_off, b_off, ilv, pend} = 6'h20;
    {mag_a, mag_b, dc_a, dc_b, ms_a, ms_b} = '0;
    repeat (6) @(negedge clk_sys);
    reset = 1'b0;
    repeat (3) @(negedge clk_sys);
    // reset values, unmapped places read zero
    chk(m_per, 24'h000080);
    for (int a = 'h100; a <= 'h11B; a++) begin
      rd(13'(a), a == 'h111 ? 8'h04 : (a == 'h113 ? 8'h80 : 8'h00));
    end
    // reserved bits stay zero, fine limits keep five high bits
    for (int i = 0; i < 7; i++) begin
      wr(ma[i], 8'hFF);
      rd(ma[i], mk[i]);
    end
    wr(13'h101, 8'hFF);
    rd(13'h101, 8'h00);
    // read-only results follow inputs and ignore writes
    dc_a = 14'h3ABC;
    dc_b = 14'h1234;
    ms_a = 20'hABCDE;
    ms_b = 20'h5F00D;
    for (int i = 0; i < 10; i++) begin
      wr(13'(i < 4 ? 'h10D + i : 'h112 + i), 8'h55);
      rd(13'(i < 4 ? 'h10D + i : 'h112 + i), ro[i]);
    end
    // period floor on the output, programmed value reads back
    wr(13'h113, 8'h10);
    wr(13'h114, 8'h00);
    wr(13'h115, 8'h00);
    chk(m_per, 24'h000080);
    rd(13'h113, 8'h10);
    wr(13'h114, 8'h01);
    chk(m_per, 24'h000110);
    // alignment gating: master off, continuous, single pulse
    wr(13'h100, 8'h86);
    pulse(0, 0);
    wr(13'h100, 8'h81);
    pulse(1, 0);
    wr(13'h100, 8'h83);
    pulse(1, 1);
    pulse(1, 1);
    wr(13'h100, 8'h87);
    pulse(1, 1);
    pulse(1, 0);
    rd(13'h100, 8'h85);
    // overrange pins: coarse level code 1, fine limits 0x300 and 0x100
    // fine limits first so the low flag stays quiet in the coarse steps
    wr(13'h106, 8'h00);
    wr(13'h107, 8'h03);
    wr(13'h108, 8'h00);
    wr(13'h109, 8'h01);
    wr(13'h105, 8'h01);
    wr(13'h104, 8'h01);
    fd(13'h0400, 2'b01);
    fd(13'h03FF, 2'b00);
    chk(fd_oe, 4'hF);
    wr(13'h104, 8'h03);
    fd(13'h0301, 2'b01);
    fd(13'h0300, 2'b00);
    fd(13'h00FF, 2'b10);
    fd(13'h0100, 2'b00);
    // interleaved: one channel off repeats the live one, both off floats
    mag_b = 13'h0500;
    ilv = 1'b1;
    b_off = 1'b1;
    fd(13'h00FF, 2'b10);
    chk(fd_out, 4'hA);
    // only channel b live: its fine high flag on both pairs
    {a_off, b_off} = 2'b10;
    repeat (4) @(negedge clk_sys);
    chk(fd_out, 4'h5);
    b_off = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk(fd_oe, 4'h0);
    {ilv, a_off, b_off} = 3'b000;
    wr(13'h104, 8'h02);
    chk(fd_oe, 4'h0);
    // shift clock divide codes and sleep while nothing pending
    wr(13'h111, 8'h71);
    chk({p_en, p_pw, p_pk, p_th}, 4'hF);
    wr(13'h111, 8'h41);
    chk({p_en, p_pw, p_pk, p_th}, 4'hC);
    wr(13'h111, 8'h05);
    ticks(8);
    wr(13'h111, 8'h09);
    ticks(4);
    wr(13'h111, 8'h0D);
    ticks(2);
    wr(13'h111, 8'h07);
    ticks(0);
    pend = 1'b1;
    ticks(8);
    // monitor mode, rms or ms, complex and enable
    for (int i = 0; i < 6; i++) begin
      wr(13'h112, cf[i]);
      chk({m_cpx, m_ms, m_src, m_en}, ce[i]);
    end
    end_sim();
  end
endmodule // test_monitor_sync_threshold_regs
`default_nettype wire
